//--- hdl/pss_defines.vh
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// Clock rate and break-before-make dead time
`define PSS_CLK_PERIOD_NS 50
`define PSS_DEAD_TIME_NS 150
`define PSS_DEAD_CYCLES ((`PSS_DEAD_TIME_NS + `PSS_CLK_PERIOD_NS - 1) / `PSS_CLK_PERIOD_NS)
`define PSS_DEAD_W 4
`define PSS_DEAD_LAST (`PSS_DEAD_CYCLES - 1)
`define PSS_DEAD_ZERO 4'h0
`define PSS_DEAD_STEP 4'h1

// Alert pulse length on a switch mismatch, in cycles
`define PSS_ALERT_PULSE_CYCLES 4'h4
`define PSS_ALERT_PULSE_END 4'h1

// Cycles a gate may disagree with its command before it counts as a fault
`define PSS_FAULT_GRACE_CYCLES 4'h8

// Selector states
`define PSS_ST_ADAPTER 2'h0
`define PSS_ST_BATTERY 2'h1
`define PSS_ST_TO_ADAPTER 2'h2
`define PSS_ST_TO_BATTERY 2'h3

// Gate levels: a high gate turns the p-channel switch off
`define PSS_GATE_OFF 1'h1
`define PSS_GATE_ON 1'h0

`endif

//--- hdl/pss_sync.v
`timescale 1ns/1ns
// Three-stage synchroniser; output changes once stages two and three agree
module pss_sync (
    input wire mclk_in,
    input wire reset_in,
    input wire async_in,
    output reg sync_out
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;

    always @(posedge mclk_in) begin
        if (reset_in) begin
            s1_ff <= 1'h0;
            s2_ff <= 1'h0;
            s3_ff <= 1'h0;
            sync_out <= 1'h0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                sync_out <= s3_ff;
            end
        end
    end
endmodule // pss_sync

//--- hdl/pss_gate_watch.v
`timescale 1ns/1ns
`include "pss_defines.vh"
// Flags a gate whose read-back stays away from its command past the grace time
module pss_gate_watch (
    input wire mclk_in,
    input wire reset_in,
    input wire command_in,
    input wire readback_in,
    input wire hold_in,
    output reg mismatch_out
);
    reg [3:0] cnt_ff;

    always @(posedge mclk_in) begin
        if (reset_in || hold_in || (command_in == readback_in)) begin
            cnt_ff <= 4'h0;
            mismatch_out <= 1'h0;
        end else if (cnt_ff == `PSS_FAULT_GRACE_CYCLES) begin
            mismatch_out <= 1'h1;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule // pss_gate_watch

//--- hdl/pss_selector.v
`timescale 1ns/1ns
`include "pss_defines.vh"
// How it works
// RL1: Sense input below threshold means adapter lost, whatever the real voltage.
// RL2: Presence output follows adapter detection, independent of selected source.
// RL3: Adapter lost while selected: switch to battery on our own.
// RL4: Adapter back: choose source from select input and presence; return if select high.
// RL5: Host holds select low to stay on battery after adapter returns.
// RL6: Battery removed while on battery with adapter present: switch to adapter.
// RL7: Variant without auto depletion switch pulses alert on switch state fault.
// RL8: Incoming switch turns on only after outgoing reads off, 150 ns dead time.
// RL9: Charging suspended whenever battery is the selected source.
// RL10: Host holds select low for a whole learn cycle.
// RL11: Select high at learn end reselects adapter only if present.
// RL12: Auto variant moves to adapter at deep discharge; other variant stays on battery.
// RL13: Alert high for as long as battery depletion lasts.
// RL14: Manual adapter selection needs presence and select input both high.
// RL15: State machine with transition states holding both gates off until read off.
module pss_selector (
    input wire mclk_in,
    input wire reset_in,
    input wire adapter_sense_in,
    input wire adapter_select_in,
    input wire depletion_level_in,
    input wire deep_discharge_in,
    input wire battery_present_in,
    input wire auto_deplete_variant_in,
    input wire adapter_gate_readback_in,
    input wire battery_gate_readback_in,
    output reg adapter_present_out,
    output reg adapter_switch_gate_out,
    output reg battery_switch_gate_out,
    output reg alert_out,
    output reg charge_suspend_out,
    output reg [1:0] state_out
);
    wire ac_ok;
    wire sel_sync;
    wire dep_sync;
    wire deep_sync;
    wire bat_sync;
    wire ac_rb;
    wire bat_rb;
    wire ac_mis;
    wire bat_mis;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [`PSS_DEAD_W-1:0] dead_ff;
    reg [`PSS_DEAD_W-1:0] nxt_dead;
    reg [3:0] pulse_ff;
    reg mis_prev_ff;
    reg want_adapter;
    reg want_battery;
    reg manual_adapter;
    reg deplete_adapter;
    reg removed_battery;
    wire var_sync;
    wire in_trans;
    wire mis_any;
    wire fault_edge;
    wire dead_done;
    wire [`PSS_DEAD_W-1:0] dead_inc;

    // Every pin from outside the clock domain goes through its own synchroniser
    pss_sync u_sync_ac (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(adapter_sense_in),
        .sync_out(ac_ok)
    );

    pss_sync u_sync_sel (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(adapter_select_in),
        .sync_out(sel_sync)
    );

    pss_sync u_sync_dep (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(depletion_level_in),
        .sync_out(dep_sync)
    );

    pss_sync u_sync_deep (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(deep_discharge_in),
        .sync_out(deep_sync)
    );

    pss_sync u_sync_bat (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(battery_present_in),
        .sync_out(bat_sync)
    );

    // Variant strap is a pin too
    pss_sync u_sync_var (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(auto_deplete_variant_in),
        .sync_out(var_sync)
    );

    // Gate read-backs
    pss_sync u_sync_acr (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(adapter_gate_readback_in),
        .sync_out(ac_rb)
    );

    pss_sync u_sync_btr (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(battery_gate_readback_in),
        .sync_out(bat_rb)
    );

    // Read-back watches pause while a transition holds both gates off
    assign in_trans = (state_ff == `PSS_ST_TO_ADAPTER) || (state_ff == `PSS_ST_TO_BATTERY);

    pss_gate_watch u_watch_ac (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .command_in(adapter_switch_gate_out),
        .readback_in(ac_rb),
        .hold_in(in_trans),
        .mismatch_out(ac_mis)
    );
    pss_gate_watch u_watch_bat (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .command_in(battery_switch_gate_out),
        .readback_in(bat_rb),
        .hold_in(in_trans),
        .mismatch_out(bat_mis)
    );

    assign mis_any = ac_mis | bat_mis;

    // Source choice
    always @* begin
        // Select high counts only with the adapter present
        manual_adapter = ac_ok && sel_sync; // RL14 RL4 RL11
        // Auto variant falls back to the adapter on deep discharge
        deplete_adapter = ac_ok && var_sync && deep_sync; // RL12
        // A removed battery forces the adapter whatever the select input says
        removed_battery = ac_ok && !bat_sync; // RL6
        want_adapter = manual_adapter || deplete_adapter || removed_battery;
        // Battery wanted on adapter loss or manual low select
        want_battery = !want_adapter; // RL3 RL5 RL10
    end

    // Dead time counter helpers
    assign dead_done = (dead_ff >= `PSS_DEAD_LAST); // RL8
    assign dead_inc = dead_ff + `PSS_DEAD_STEP;

    // Selector state machine
    always @* begin
        nxt_state = state_ff;
        nxt_dead = dead_ff;
        case (state_ff)
            `PSS_ST_ADAPTER: begin
                if (want_battery) begin
                    nxt_state = `PSS_ST_TO_BATTERY; // RL3
                    nxt_dead = `PSS_DEAD_ZERO;
                end
            end

            `PSS_ST_BATTERY: begin
                if (want_adapter) begin
                    nxt_state = `PSS_ST_TO_ADAPTER; // RL4 RL6
                    nxt_dead = `PSS_DEAD_ZERO;
                end
            end

            `PSS_ST_TO_BATTERY: begin
                // Both gates off; wait for adapter gate read back off, then dead time
                if (ac_rb == `PSS_GATE_OFF) begin // RL15
                    if (dead_done) begin // RL8
                        nxt_state = `PSS_ST_BATTERY;
                    end else begin
                        nxt_dead = dead_inc;
                    end
                end
            end

            `PSS_ST_TO_ADAPTER: begin
                // Adapter lost before the switch-over: turn back, its gate never opened
                if (want_battery) begin
                    nxt_state = `PSS_ST_TO_BATTERY; // RL14 RL3
                    nxt_dead = `PSS_DEAD_ZERO;
                end else if (bat_rb == `PSS_GATE_OFF) begin // RL15
                    if (dead_done) begin // RL8
                        nxt_state = `PSS_ST_ADAPTER;
                    end else begin
                        nxt_dead = dead_inc;
                    end
                end
            end

            default: begin
                nxt_state = `PSS_ST_BATTERY;
                nxt_dead = `PSS_DEAD_ZERO;
            end
        endcase
    end

    // State and dead-time registers
    always @(posedge mclk_in) begin
        if (reset_in) begin
            state_ff <= `PSS_ST_BATTERY;
            dead_ff <= `PSS_DEAD_ZERO;
        end else begin
            state_ff <= nxt_state;
            dead_ff <= nxt_dead;
        end
    end

    // Presence follows the synchronised sense input, whatever source is in use
    always @(posedge mclk_in) begin
        if (reset_in) begin
            adapter_present_out <= 1'h0;
            state_out <= `PSS_ST_BATTERY;
        end else begin
            adapter_present_out <= ac_ok; // RL1 RL2
            state_out <= nxt_state;
        end
    end

    // Gate drives and charge suspend, decoded from next state
    always @(posedge mclk_in) begin
        if (reset_in) begin
            adapter_switch_gate_out <= `PSS_GATE_OFF;
            battery_switch_gate_out <= `PSS_GATE_ON;
            charge_suspend_out <= 1'h1;
        end else begin
            // Transitions hold both gates off; the new gate waits for the dead time
            case (nxt_state)
                `PSS_ST_ADAPTER: begin
                    adapter_switch_gate_out <= `PSS_GATE_ON;
                    battery_switch_gate_out <= `PSS_GATE_OFF;
                    charge_suspend_out <= 1'h0;
                end
                `PSS_ST_BATTERY: begin
                    adapter_switch_gate_out <= `PSS_GATE_OFF; // RL3
                    battery_switch_gate_out <= `PSS_GATE_ON;
                    charge_suspend_out <= 1'h1; // RL9
                end

                `PSS_ST_TO_ADAPTER: begin
                    // Battery gate opens first; the adapter gate waits for its read back
                    adapter_switch_gate_out <= `PSS_GATE_OFF; // RL15
                    battery_switch_gate_out <= `PSS_GATE_OFF; // RL8
                    charge_suspend_out <= 1'h1; // RL9
                end

                `PSS_ST_TO_BATTERY: begin
                    adapter_switch_gate_out <= `PSS_GATE_OFF; // RL15
                    battery_switch_gate_out <= `PSS_GATE_OFF; // RL8
                    charge_suspend_out <= 1'h1; // RL9
                end

                default: begin
                    adapter_switch_gate_out <= `PSS_GATE_OFF;
                    battery_switch_gate_out <= `PSS_GATE_OFF;
                    charge_suspend_out <= 1'h1;
                end
            endcase
        end
    end

    // A fresh switch fault raises the pulse, only in the manual variant
    assign fault_edge = !var_sync && mis_any && !mis_prev_ff; // RL7

    // Alert: level for depletion, pulse on a new switch fault in manual variant
    always @(posedge mclk_in) begin
        if (reset_in) begin
            pulse_ff <= 4'h0;
            mis_prev_ff <= 1'h0;
            alert_out <= 1'h0;
        end else begin
            mis_prev_ff <= mis_any;
            if (fault_edge) begin
                pulse_ff <= `PSS_ALERT_PULSE_CYCLES; // RL7
            end else if (pulse_ff != 4'h0) begin
                pulse_ff <= pulse_ff - 4'h1;
            end
            // Depletion holds the alert up whatever source is selected
            if (dep_sync) begin
                alert_out <= 1'h1; // RL13
            end else if (fault_edge) begin
                alert_out <= 1'h1; // RL7
            end else begin
                alert_out <= (pulse_ff > `PSS_ALERT_PULSE_END); // RL7
            end
        end
    end
endmodule // pss_selector

//--- tb/pss_switch_model.sv
`timescale 1ns/1ns
// External switches: gate level reads back two cycles late; stuck_in jams the adapter read-back off
module pss_switch_model (
    input wire logic mclk_in,
    input wire logic adapter_gate_in,
    input wire logic battery_gate_in,
    input wire logic stuck_in,
    output logic adapter_readback_out,
    output logic battery_readback_out
);
    logic [1:0] a_dly_ff = 2'h3;
    logic [1:0] b_dly_ff = 2'h0;
    always @(posedge mclk_in) begin
        a_dly_ff <= {a_dly_ff[0], adapter_gate_in};
        b_dly_ff <= {b_dly_ff[0], battery_gate_in};
    end
    assign adapter_readback_out = a_dly_ff[1] | stuck_in;
    assign battery_readback_out = b_dly_ff[1];
endmodule // pss_switch_model

//--- tb/pss_selector_chk.sv
`timescale 1ns/1ns
module pss_selector_chk (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic adapter_sense_in,
    input wire logic depletion_level_in,
    input wire logic adapter_gate_readback_in,
    input wire logic battery_gate_readback_in,
    input wire logic adapter_present_out,
    input wire logic adapter_switch_gate_out,
    input wire logic battery_switch_gate_out,
    input wire logic alert_out,
    input wire logic charge_suspend_out,
    input wire logic [1:0] state_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    AST_NO_SHOOT: assert property (adapter_switch_gate_out || battery_switch_gate_out)
        else $error("both switches on");
    AST_TRANS_OFF: assert property (state_out[1] |-> adapter_switch_gate_out && battery_switch_gate_out)
        else $error("gate on during transition");
    AST_ADP_GATES: assert property (state_out == 2'h0 |-> !adapter_switch_gate_out && battery_switch_gate_out)
        else $error("adapter state gates wrong");
    AST_BAT_GATES: assert property (state_out == 2'h1 |-> adapter_switch_gate_out && !battery_switch_gate_out)
        else $error("battery state gates wrong");
    AST_BAT_ON: assert property ($fell(battery_switch_gate_out) |-> $past(adapter_gate_readback_in, 4))
        else $error("battery on before adapter read off");
    AST_ADP_ON: assert property ($fell(adapter_switch_gate_out) |-> $past(battery_gate_readback_in, 4))
        else $error("adapter on before battery read off");
    AST_SUSPEND: assert property (state_out == 2'h1 |-> charge_suspend_out)
        else $error("charging on battery");
    AST_NEED_PRES: assert property (state_out == 2'h0 |-> adapter_present_out)
        else $error("adapter selected while absent");
    AST_LOST: assert property (!adapter_sense_in [*8] |-> !adapter_present_out)
        else $error("presence kept after loss");
    AST_FOUND: assert property (adapter_sense_in [*8] |-> adapter_present_out)
        else $error("presence missing");
    AST_DEPL: assert property (depletion_level_in [*8] |-> alert_out)
        else $error("alert low while depleted");
    COV_TO_BAT: cover property (state_out == 2'h3);
    COV_TO_ADP: cover property (state_out == 2'h2);
    COV_ALERT: cover property ($rose(alert_out));
    COV_ABORT: cover property (state_out == 2'h2 ##1 state_out == 2'h3);
endmodule // pss_selector_chk
bind pss_selector pss_selector_chk pss_selector_chk_inst (.mclk_in(mclk_in), .reset_in(reset_in),
    .adapter_sense_in(adapter_sense_in), .depletion_level_in(depletion_level_in),
    .adapter_gate_readback_in(adapter_gate_readback_in), .battery_gate_readback_in(battery_gate_readback_in),
    .adapter_present_out(adapter_present_out), .adapter_switch_gate_out(adapter_switch_gate_out),
    .battery_switch_gate_out(battery_switch_gate_out), .alert_out(alert_out),
    .charge_suspend_out(charge_suspend_out), .state_out(state_out));

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
    logic mclk_in = 1'h0;
    logic reset_in = 1'h1;
    logic sense = 1'h0, sel = 1'h0, dep = 1'h0, deep = 1'h0, bpres = 1'h1, vari = 1'h0, stuck = 1'h0;
    wire a_rb, b_rb, pres, a_gate, b_gate, alert, susp;
    wire [1:0] state_out;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #25 mclk_in = ~mclk_in;
    pss_selector pss_selector_inst (.mclk_in(mclk_in), .reset_in(reset_in), .adapter_sense_in(sense),
        .adapter_select_in(sel), .depletion_level_in(dep), .deep_discharge_in(deep), .battery_present_in(bpres),
        .auto_deplete_variant_in(vari), .adapter_gate_readback_in(a_rb), .battery_gate_readback_in(b_rb),
        .adapter_present_out(pres), .adapter_switch_gate_out(a_gate), .battery_switch_gate_out(b_gate),
        .alert_out(alert), .charge_suspend_out(susp), .state_out(state_out));
    pss_switch_model pss_switch_model_inst (.mclk_in(mclk_in), .adapter_gate_in(a_gate),
        .battery_gate_in(b_gate), .stuck_in(stuck), .adapter_readback_out(a_rb), .battery_readback_out(b_rb));
    task close_out;
        $display("checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task check(input logic [3:0] seen, input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge mclk_in);
        #5;
    endtask
    task expect_st(input logic [1:0] s);
        int i;
        for (i = 0; i < 80 && state_out !== s; i++) step(1);
        check({2'h0, state_out}, {2'h0, s});
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        step(12);
        reset_in = 1'h0;
        check({a_gate, b_gate, pres, susp}, 4'h9);
        check({2'h0, state_out}, 4'h1);
        sense = 1'h1;
        sel = 1'h1;
        expect_st(2'h0);
        check({pres, susp}, 4'h2);
        sense = 1'h0;
        expect_st(2'h1);
        check({3'h0, pres}, 4'h0);
        sel = 1'h0;
        sense = 1'h1;
        step(40);
        check({2'h0, state_out}, 4'h1);
        check({3'h0, pres}, 4'h1);
        sel = 1'h1;
        expect_st(2'h0);
        sel = 1'h0;
        expect_st(2'h1);
        check({3'h0, susp}, 4'h1);
        bpres = 1'h0;
        expect_st(2'h0);
        sel = 1'h1;
        bpres = 1'h1;
        stuck = 1'h1;
        for (int i = 0; i < 40 && alert !== 1'h1; i++) step(1);
        check({3'h0, alert}, 4'h1);
        step(10);
        check({3'h0, alert}, 4'h0);
        stuck = 1'h0;
        step(20);
        dep = 1'h1;
        step(10);
        check({3'h0, alert}, 4'h1);
        sel = 1'h0;
        deep = 1'h1;
        expect_st(2'h1);
        step(40);
        check({2'h0, state_out}, 4'h1);
        check({3'h0, alert}, 4'h1);
        sel = 1'h1;
        expect_st(2'h2);
        sense = 1'h0;
        step(6);
        check({2'h0, state_out}, 4'h3);
        expect_st(2'h1);
        sense = 1'h1;
        sel = 1'h0;
        reset_in = 1'h1;
        vari = 1'h1;
        step(5);
        reset_in = 1'h0;
        step(2);
        expect_st(2'h0);
        check({3'h0, alert}, 4'h1);
        close_out();
    end
endmodule // tb
